// *** switch_queue_map.svh ***
// Register offsets, field positions and reset values of the queue partition block
`ifndef SWITCH_QUEUE_MAP_SVH
`define SWITCH_QUEUE_MAP_SVH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_PARTITION_SIZES 7'h3E
`define IDX_TX_FRAME_COUNT  7'h3F
`define IDX_HALFWORD_LEVEL  7'h40
`define IDX_OVERFLOW_DROPS  7'h41
`define IDX_ECC_LOCATION    7'h42
`define IDX_QUEUE_CONTROL   7'h4A
`define IDX_IRQ_STATUS      7'h4B
`define IDX_IRQ_MASK        7'h4C

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define SIZE_RESET          32'h02222222
`define SIZE_USED_MASK      32'h0FFFFFFF
`define SIZE_FIELD_COUNT    7
`define SIZE_CODE_MAX       4'h8
`define HALFWORDS_PER_STEP  14'h0400
`define TOTAL_STEPS_MAX     7'h0E
`define FRAME_COUNT_W       9
`define LEVEL_W             14
`define ECC_LOCATION_W      14
`define CTRL_CLEAR_BIT      0
`define IRQ_DROP_BIT        0
`define IRQ_REJECT_BIT      1
`define IRQ_COUNT           2

`endif

// *** switch_queue_pkg.sv ***
// Types shared by the queue partition block
package switch_queue_pkg;

	typedef enum logic [1:0] {
		HTX_IDLE  = 2'b00,
		HTX_STORE = 2'b01,
		HTX_DROP  = 2'b11
	} htx_state_e;

	typedef logic [3:0]  size_code_t;
	typedef logic [13:0] halfword_level_t;

endpackage

// *** partition_size_check.sv ***
// Decode and sanity check of a candidate queue partition size word
`timescale 1ns/1ps
`include "switch_queue_map.svh"

module partition_size_check (
	input  wire logic [31:0] size_word,
	output logic             size_ok,
	output logic [13:0]      host_capacity
);

	logic [6:0] total_steps;
	logic       codes_ok;

	always_comb begin
		total_steps = 7'h00;
		codes_ok    = 1'b1;
		for (int i = 0; i < `SIZE_FIELD_COUNT; i++) begin
			if (size_word[i*4 +: 4] > `SIZE_CODE_MAX) begin
				codes_ok = 1'b0;
			end
			total_steps = 7'(total_steps + {3'h0, size_word[i*4 +: 4]});
		end
		// Combined capacity above the shared buffer would overrun neighbours
		size_ok       = codes_ok && (total_steps <= `TOTAL_STEPS_MAX);
		// Host queue in 2 kB steps, 1024 half words each
		host_capacity = 14'(size_word[3:0] * `HALFWORDS_PER_STEP);
	end

endmodule

// *** sticky_irq.sv ***
// Sticky event status with mask and one level interrupt
`timescale 1ns/1ps

module sticky_irq #(
	parameter int N = 2
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [N-1:0] event_set,
	input  wire logic [N-1:0] clear_ones,
	input  wire logic [N-1:0] mask_next,
	input  wire logic         mask_load,
	output logic [N-1:0]      status,
	output logic [N-1:0]      mask,
	output logic              irq
);

	logic [N-1:0] status_r;
	logic [N-1:0] status_nxt;
	logic [N-1:0] mask_r;
	logic [N-1:0] mask_nxt;
	logic         irq_r;
	logic         irq_nxt;

	always_comb begin
		// A new event beats a clear in the same cycle
		status_nxt = (status_r & ~clear_ones) | event_set;
		mask_nxt   = mask_load ? mask_next : mask_r;
		irq_nxt    = |(status_nxt & mask_nxt);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_r <= '0;
			mask_r   <= '0;
			irq_r    <= 1'b0;
		end else begin
			status_r <= status_nxt;
			mask_r   <= mask_nxt;
			irq_r    <= irq_nxt;
		end
	end

	assign status = status_r;
	assign mask   = mask_r;
	assign irq    = irq_r;

endmodule

// *** switch_queue_partition.sv ***
// Queue partition register, host transmit queue status counters and Wishbone slave
//
// Overview of operation
// - Queue clear must precede a size write; size writes are ignored until cleared.
// - Each 4-bit size code counts 2 kB steps, 0000 none to 1000 16 kB; p1-to-p2 in 27:24.
// - Port 2 to port 1 transmit queue size comes from bits 23:20.
// - Port 2 high receive queue from bits 19:16, low receive queue from 15:12.
// - Port 1 high receive queue from bits 11:8, low receive queue from 7:4.
// - Host transmit queue size comes from bits 3:0.
// - Size register resets to 4 kB codes everywhere; bits 31:28 read zero.
// - Read-only 9-bit count of frames held in the transmit queue, reset zero.
// - Read-only 14-bit count of valid half words in host transmit queue, reset zero.
// - Read-only 32-bit count of host frames dropped on overflow, reset zero.
`timescale 1ns/1ps
`include "switch_queue_map.svh"

module switch_queue_partition #(
	parameter int LEVEL_W       = `LEVEL_W,
	parameter int FRAME_COUNT_W = `FRAME_COUNT_W
) (
	input  wire logic        REF_CLK,
	input  wire logic        RST_N,
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	input  wire logic        WE_I,
	input  wire logic [8:2]  ADR_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic [31:0] DAT_I,
	output logic      [31:0] DAT_O,
	output logic             ACK_O,
	output logic             IRQ,
	input  wire logic        HTX_WR_VALID,
	input  wire logic        HTX_WR_LAST,
	input  wire logic        HTX_RD_VALID,
	input  wire logic        HTX_RD_LAST,
	input  wire logic [13:0] ECC_ERR_LOCATION,
	output logic             HTX_FULL,
	output logic             QUEUE_CLEAR,
	output logic [3:0]       P1_TO_P2_TX_QUEUE_SIZE,
	output logic [3:0]       P2_TO_P1_TX_QUEUE_SIZE,
	output logic [3:0]       PORT2_RX_HIGH_QUEUE_SIZE,
	output logic [3:0]       PORT2_RX_LOW_QUEUE_SIZE,
	output logic [3:0]       PORT1_RX_HIGH_QUEUE_SIZE,
	output logic [3:0]       PORT1_RX_LOW_QUEUE_SIZE,
	output logic [3:0]       HOST_TX_QUEUE_SIZE
);

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	if (LEVEL_W != `LEVEL_W) begin : g_bad_level
		$error("level width must match the 14-bit status field");
	end
	if (FRAME_COUNT_W != `FRAME_COUNT_W) begin : g_bad_count
		$error("frame count width must match the 9-bit status field");
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta_r;
	logic rst_sync_r;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic        ack_r;
	logic        ack_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic        bus_take;
	logic        wr_take;

	// Accesses take effect on the edge that raises ack, never twice
	assign bus_take = CYC_I && STB_I && !ack_r;
	assign wr_take  = bus_take && WE_I;

	// ----------------------------------------------------------------
	// Partition sizes and queue clear
	// ----------------------------------------------------------------
	logic [31:0] size_r;
	logic [31:0] size_nxt;
	logic [31:0] size_candidate;
	logic        size_ok;
	logic [13:0] cand_capacity;
	logic [13:0] host_cap_r;
	logic [13:0] host_cap_nxt;
	logic        armed_r;
	logic        armed_nxt;
	logic        clear_r;
	logic        clear_nxt;
	logic        size_wr;
	logic        reject_evt;

	assign size_candidate = merge_bytes(size_r, DAT_I, SEL_I) & `SIZE_USED_MASK;
	assign size_wr        = wr_take && (ADR_I == `IDX_PARTITION_SIZES);

	partition_size_check u_check (
		.size_word     (size_candidate),
		.size_ok       (size_ok),
		.host_capacity (cand_capacity)
	);

	always_comb begin
		size_nxt     = size_r;
		host_cap_nxt = host_cap_r;
		armed_nxt    = armed_r;
		clear_nxt    = 1'b0;
		reject_evt   = 1'b0;
		if (wr_take && (ADR_I == `IDX_QUEUE_CONTROL) && SEL_I[0] && DAT_I[`CTRL_CLEAR_BIT]) begin
			clear_nxt = 1'b1;
			armed_nxt = 1'b1;
		end else if (HTX_WR_VALID) begin
			// Traffic resumed: resizing now would corrupt live queues
			armed_nxt = 1'b0;
		end
		if (size_wr) begin
			if (armed_r && size_ok) begin
				size_nxt     = size_candidate;
				host_cap_nxt = cand_capacity;
			end else begin
				reject_evt = 1'b1;
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			size_r     <= `SIZE_RESET;
			host_cap_r <= 14'h0800;
			armed_r    <= 1'b0;
			clear_r    <= 1'b0;
		end else begin
			size_r     <= size_nxt;
			host_cap_r <= host_cap_nxt;
			armed_r    <= armed_nxt;
			clear_r    <= clear_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Host transmit queue tracking
	// ----------------------------------------------------------------
	switch_queue_pkg::htx_state_e state_r;
	switch_queue_pkg::htx_state_e state_nxt;
	logic [13:0] level_r;
	logic [13:0] level_nxt;
	logic [13:0] frame_words_r;
	logic [13:0] frame_words_nxt;
	logic [8:0]  frames_r;
	logic [8:0]  frames_nxt;
	logic [31:0] drops_r;
	logic [31:0] drops_nxt;
	logic        full_r;
	logic        full_nxt;
	logic        drop_evt;
	logic        wr_acc;
	logic        wr_over;
	logic        rd_acc;
	logic        commit;
	logic        unframe;
	logic [13:0] rollback;

	always_comb begin
		state_nxt       = state_r;
		frame_words_nxt = frame_words_r;
		drops_nxt       = drops_r;
		drop_evt        = 1'b0;
		wr_acc          = 1'b0;
		wr_over         = 1'b0;
		commit          = 1'b0;
		rollback        = 14'h0000;
		rd_acc          = HTX_RD_VALID && (level_r != 14'h0000);
		unframe         = rd_acc && HTX_RD_LAST && (frames_r != 9'h000);
		if (HTX_WR_VALID) begin
			unique case (state_r)
				switch_queue_pkg::HTX_IDLE,
				switch_queue_pkg::HTX_STORE: begin
					if (level_r >= host_cap_r) begin
						// Overflow: discard the partial frame already stored
						wr_over         = 1'b1;
						rollback        = frame_words_r;
						frame_words_nxt = 14'h0000;
						state_nxt       = switch_queue_pkg::HTX_DROP;
					end else begin
						wr_acc          = 1'b1;
						frame_words_nxt = 14'(frame_words_r + 14'h0001);
						state_nxt       = switch_queue_pkg::HTX_STORE;
					end
				end
				switch_queue_pkg::HTX_DROP: begin
					wr_over = 1'b1;
				end
				default: begin
					state_nxt = switch_queue_pkg::HTX_IDLE;
				end
			endcase
			if (HTX_WR_LAST) begin
				frame_words_nxt = 14'h0000;
				state_nxt       = switch_queue_pkg::HTX_IDLE;
				if (wr_over) begin
					drops_nxt = 32'(drops_r + 32'h00000001);
					drop_evt  = 1'b1;
				end else begin
					commit = 1'b1;
				end
			end
		end
		// Counters move in the same cycle as the word itself
		level_nxt  = 14'(level_r + {13'h0000, wr_acc} - {13'h0000, rd_acc} - rollback);
		frames_nxt = 9'(frames_r + {8'h00, commit} - {8'h00, unframe});
		if (clear_r) begin
			state_nxt       = switch_queue_pkg::HTX_IDLE;
			frame_words_nxt = 14'h0000;
			level_nxt       = 14'h0000;
			frames_nxt      = 9'h000;
		end
		full_nxt = (level_nxt >= host_cap_r);
	end

	always_ff @(posedge REF_CLK or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			state_r       <= switch_queue_pkg::HTX_IDLE;
			level_r       <= 14'h0000;
			frame_words_r <= 14'h0000;
			frames_r      <= 9'h000;
			drops_r       <= 32'h00000000;
			full_r        <= 1'b0;
		end else begin
			state_r       <= state_nxt;
			level_r       <= level_nxt;
			frame_words_r <= frame_words_nxt;
			frames_r      <= frames_nxt;
			drops_r       <= drops_nxt;
			full_r        <= full_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	logic [1:0]  irq_status;
	logic [1:0]  irq_mask;
	logic [1:0]  irq_clear;
	logic [1:0]  irq_set;
	logic [31:0] mask_word;
	logic        irq_w;

	assign irq_set   = {reject_evt, drop_evt};
	assign irq_clear = (wr_take && (ADR_I == `IDX_IRQ_STATUS) && SEL_I[0]) ? DAT_I[1:0] : 2'h0;
	assign mask_word = merge_bytes({30'h0, irq_mask}, DAT_I, SEL_I);

	sticky_irq #(
		.N (`IRQ_COUNT)
	) u_irq (
		.clk        (REF_CLK),
		.rst_n      (rst_sync_r),
		.event_set  (irq_set),
		.clear_ones (irq_clear),
		.mask_next  (mask_word[1:0]),
		.mask_load  (wr_take && (ADR_I == `IDX_IRQ_MASK)),
		.status     (irq_status),
		.mask       (irq_mask),
		.irq        (irq_w)
	);

	// ----------------------------------------------------------------
	// Read path and answer
	// ----------------------------------------------------------------
	logic [13:0] ecc_loc_r;

	always_ff @(posedge REF_CLK or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			ecc_loc_r <= 14'h0000;
		end else begin
			ecc_loc_r <= ECC_ERR_LOCATION;
		end
	end

	always_comb begin
		ack_nxt   = bus_take;
		rdata_nxt = 32'h00000000;
		if (bus_take && !WE_I) begin
			unique case (ADR_I)
				`IDX_PARTITION_SIZES: rdata_nxt = size_r;
				`IDX_TX_FRAME_COUNT:  rdata_nxt = {23'h000000, frames_r};
				`IDX_HALFWORD_LEVEL:  rdata_nxt = {18'h00000, level_r};
				`IDX_OVERFLOW_DROPS:  rdata_nxt = drops_r;
				`IDX_ECC_LOCATION:    rdata_nxt = {18'h00000, ecc_loc_r};
				`IDX_QUEUE_CONTROL:   rdata_nxt = {31'h00000000, armed_r};
				`IDX_IRQ_STATUS:      rdata_nxt = {30'h00000000, irq_status};
				`IDX_IRQ_MASK:        rdata_nxt = {30'h00000000, irq_mask};
				default:              rdata_nxt = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h00000000;
		end else begin
			ack_r   <= ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign ACK_O                    = ack_r;
	assign DAT_O                    = rdata_r;
	assign IRQ                      = irq_w;
	assign HTX_FULL                 = full_r;
	assign QUEUE_CLEAR              = clear_r;
	assign P1_TO_P2_TX_QUEUE_SIZE   = size_r[27:24];
	assign P2_TO_P1_TX_QUEUE_SIZE   = size_r[23:20];
	assign PORT2_RX_HIGH_QUEUE_SIZE = size_r[19:16];
	assign PORT2_RX_LOW_QUEUE_SIZE  = size_r[15:12];
	assign PORT1_RX_HIGH_QUEUE_SIZE = size_r[11:8];
	assign PORT1_RX_LOW_QUEUE_SIZE  = size_r[7:4];
	assign HOST_TX_QUEUE_SIZE       = size_r[3:0];

endmodule

// *** switch_queue_partition_properties.sv ***
// Port-level checker for the queue partition block
`timescale 1ns/1ps
`include "switch_queue_map.svh"

module queue_partition_checker (
	input wire logic        REF_CLK,
	input wire logic        RST_N,
	input wire logic        CYC_I,
	input wire logic        STB_I,
	input wire logic        WE_I,
	input wire logic [8:2]  ADR_I,
	input wire logic [31:0] DAT_O,
	input wire logic        ACK_O,
	input wire logic        QUEUE_CLEAR,
	input wire logic [3:0]  P1_TO_P2_TX_QUEUE_SIZE,
	input wire logic [3:0]  P2_TO_P1_TX_QUEUE_SIZE,
	input wire logic [3:0]  PORT2_RX_HIGH_QUEUE_SIZE,
	input wire logic [3:0]  PORT2_RX_LOW_QUEUE_SIZE,
	input wire logic [3:0]  PORT1_RX_HIGH_QUEUE_SIZE,
	input wire logic [3:0]  PORT1_RX_LOW_QUEUE_SIZE,
	input wire logic [3:0]  HOST_TX_QUEUE_SIZE
);
	// ------
	// Helpers
	// ------
	logic [27:0] codes;
	logic [6:0]  steps;
	logic        big;
	logic        sz_wr;
	logic        clr_wr;
	assign codes = {P1_TO_P2_TX_QUEUE_SIZE, P2_TO_P1_TX_QUEUE_SIZE, PORT2_RX_HIGH_QUEUE_SIZE,
		PORT2_RX_LOW_QUEUE_SIZE, PORT1_RX_HIGH_QUEUE_SIZE, PORT1_RX_LOW_QUEUE_SIZE, HOST_TX_QUEUE_SIZE};
	assign sz_wr = ACK_O && WE_I && ADR_I == `IDX_PARTITION_SIZES;
	assign clr_wr = ACK_O && WE_I && ADR_I == `IDX_QUEUE_CONTROL;
	always_comb begin
		steps = 7'h00;
		big = 1'b0;
		for (int i = 0; i < 7; i++) begin
			steps = steps + {3'h0, codes[4*i +: 4]};
			big = big | (codes[4*i +: 4] > 4'h8);
		end
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	// ------
	// Properties
	// ------
	property p_ack_take; CYC_I && STB_I && !ACK_O |=> ACK_O; endproperty
	a_ack_take: assert property (p_ack_take) else $error("ack missing after request");
	property p_ack_pulse; ACK_O |=> !ACK_O; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_ack_cause; ACK_O |-> $past(CYC_I && STB_I); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_dat_idle; !ACK_O |-> DAT_O == 32'h0; endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
	// Sizes move only through an accepted size write
	property p_size_hold; $changed(codes) |-> sz_wr || $past(sz_wr); endproperty
	a_size_hold: assert property (p_size_hold) else $error("size codes changed unasked");
	property p_size_legal; !big && steps <= 7'h0E; endproperty
	a_size_legal: assert property (p_size_legal) else $error("illegal size codes held");
	property p_clear_pulse; QUEUE_CLEAR |=> !QUEUE_CLEAR; endproperty
	a_clear_pulse: assert property (p_clear_pulse) else $error("clear longer than one cycle");
	property p_clear_cause; QUEUE_CLEAR |-> clr_wr || $past(clr_wr); endproperty
	a_clear_cause: assert property (p_clear_cause) else $error("clear without control write");
	property p_reset_sizes; $rose(RST_N) |-> codes == 28'h2222222; endproperty
	a_reset_sizes: assert property (p_reset_sizes) else $error("size codes wrong at reset");
endmodule

bind switch_queue_partition queue_partition_checker u_queue_partition_checker (.REF_CLK, .RST_N, .CYC_I,
	.STB_I, .WE_I, .ADR_I, .DAT_O, .ACK_O, .QUEUE_CLEAR, .P1_TO_P2_TX_QUEUE_SIZE, .P2_TO_P1_TX_QUEUE_SIZE,
	.PORT2_RX_HIGH_QUEUE_SIZE, .PORT2_RX_LOW_QUEUE_SIZE, .PORT1_RX_HIGH_QUEUE_SIZE,
	.PORT1_RX_LOW_QUEUE_SIZE, .HOST_TX_QUEUE_SIZE);

// *** host_mac_model.sv ***
// Host and port MAC stand-in that fills and drains the host transmit queue
`timescale 1ns/1ps

module host_mac_model (
	input wire logic REF_CLK,
	output logic     HTX_WR_VALID,
	output logic     HTX_WR_LAST,
	output logic     HTX_RD_VALID,
	output logic     HTX_RD_LAST
);
	// ------
	// Idle until told, so traffic is stopped while sizes change
	// ------
	initial begin
		HTX_WR_VALID = 1'b0;
		HTX_WR_LAST = 1'b0;
		HTX_RD_VALID = 1'b0;
		HTX_RD_LAST = 1'b0;
	end

	// One frame of n half words; gap idles between words for a slow side
	task automatic move(input int n, input bit rd, input int gap);
		for (int i = 0; i < n; i++) begin
			HTX_WR_VALID <= !rd;
			HTX_WR_LAST <= !rd && i == n - 1;
			HTX_RD_VALID <= rd;
			HTX_RD_LAST <= rd && i == n - 1;
			@(posedge REF_CLK);
			if (gap > 0) begin
				HTX_WR_VALID <= 1'b0;
				HTX_RD_VALID <= 1'b0;
				repeat (gap) @(posedge REF_CLK);
			end
		end
		HTX_WR_VALID <= 1'b0;
		HTX_WR_LAST <= 1'b0;
		HTX_RD_VALID <= 1'b0;
		HTX_RD_LAST <= 1'b0;
		@(posedge REF_CLK);
	endtask
endmodule

// *** test_switch_queue_partition.sv ***
// Self-checking bench for the queue partition block
`timescale 1ns/1ps

module test_switch_queue_partition;
	// ------
	// Signals
	// ------
	typedef struct packed {logic [6:0] adr; logic [31:0] val;} row_s;
	logic        REF_CLK = 1'b0, RST_N = 1'b0;
	logic        CYC_I = 1'b0, STB_I = 1'b0, WE_I = 1'b0;
	logic [8:2]  ADR_I = 7'h00;
	logic [3:0]  SEL_I = 4'hF;
	logic [31:0] DAT_I = 32'h0;
	logic [13:0] ECC_ERR_LOCATION = 14'h0155;
	logic [31:0] DAT_O, ports, v;
	logic        ACK_O, IRQ, HTX_FULL, QUEUE_CLEAR;
	logic        HTX_WR_VALID, HTX_WR_LAST, HTX_RD_VALID, HTX_RD_LAST;
	logic [3:0]  P1_TO_P2_TX_QUEUE_SIZE, P2_TO_P1_TX_QUEUE_SIZE, PORT2_RX_HIGH_QUEUE_SIZE;
	logic [3:0]  PORT2_RX_LOW_QUEUE_SIZE, PORT1_RX_HIGH_QUEUE_SIZE, PORT1_RX_LOW_QUEUE_SIZE;
	logic [3:0]  HOST_TX_QUEUE_SIZE;
	int          error_cnt = 0, checks = 0;
	row_s        rows [9] = '{{7'h3E, 32'h02222222}, {7'h3F, 32'h0}, {7'h40, 32'h0}, {7'h41, 32'h0},
		{7'h42, 32'h155}, {7'h4A, 32'h0}, {7'h4B, 32'h0}, {7'h4C, 32'h0}, {7'h50, 32'h0}};
	assign ports = {4'h0, P1_TO_P2_TX_QUEUE_SIZE, P2_TO_P1_TX_QUEUE_SIZE, PORT2_RX_HIGH_QUEUE_SIZE,
		PORT2_RX_LOW_QUEUE_SIZE, PORT1_RX_HIGH_QUEUE_SIZE, PORT1_RX_LOW_QUEUE_SIZE, HOST_TX_QUEUE_SIZE};

	switch_queue_partition u_switch_queue_partition (.REF_CLK, .RST_N, .CYC_I, .STB_I, .WE_I, .ADR_I,
		.SEL_I, .DAT_I, .DAT_O, .ACK_O, .IRQ, .HTX_WR_VALID, .HTX_WR_LAST, .HTX_RD_VALID, .HTX_RD_LAST,
		.ECC_ERR_LOCATION, .HTX_FULL, .QUEUE_CLEAR, .P1_TO_P2_TX_QUEUE_SIZE, .P2_TO_P1_TX_QUEUE_SIZE,
		.PORT2_RX_HIGH_QUEUE_SIZE, .PORT2_RX_LOW_QUEUE_SIZE, .PORT1_RX_HIGH_QUEUE_SIZE,
		.PORT1_RX_LOW_QUEUE_SIZE, .HOST_TX_QUEUE_SIZE);
	host_mac_model u_host_mac_model (.REF_CLK, .HTX_WR_VALID, .HTX_WR_LAST, .HTX_RD_VALID, .HTX_RD_LAST);

	always #4 REF_CLK = ~REF_CLK;

	// ------
	// Tasks
	// ------
	task stop_test;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Classic cycle: hold until ack is sampled, then release for a cycle
	task wb(input logic we, input logic [6:0] adr, input logic [31:0] wd);
		int n;
		n = 0;
		CYC_I <= 1'b1;
		STB_I <= 1'b1;
		WE_I <= we;
		ADR_I <= adr;
		DAT_I <= wd;
		do begin
			@(posedge REF_CLK);
			n++;
		end while (ACK_O !== 1'b1 && n < 50);
		if (n == 50) begin
			error_cnt++;
			stop_test;
		end
		v = DAT_O;
		CYC_I <= 1'b0;
		STB_I <= 1'b0;
		@(posedge REF_CLK);
	endtask

	task rdc(input string nm, input logic [6:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 32'h0);
		chk(nm, exp, v);
	endtask

	task do_reset;
		RST_N <= 1'b0;
		repeat (10) @(posedge REF_CLK);
		RST_N <= 1'b1;
		repeat (3) @(posedge REF_CLK);
	endtask

	// ------
	// Sequence
	// ------
	initial begin
		do_reset;
		chk("size ports", 32'h02222222, ports);
		foreach (rows[i]) rdc("reset row", rows[i].adr, rows[i].val);
		wb(1'b1, 7'h3E, 32'h01111111);
		rdc("size unarmed", 7'h3E, 32'h02222222);
		rdc("irq status", 7'h4B, 32'h2);
		wb(1'b1, 7'h4A, 32'h1);
		rdc("armed", 7'h4A, 32'h1);
		for (int c = 0; c < 9; c++) begin
			wb(1'b1, 7'h3E, {28'h0, 4'(c)} << (4 * (c % 7)));
			rdc("size code", 7'h3E, {28'h0, 4'(c)} << (4 * (c % 7)));
			chk("size ports", {28'h0, 4'(c)} << (4 * (c % 7)), ports);
		end
		wb(1'b1, 7'h3E, 32'hF1203412);
		rdc("size word", 7'h3E, 32'h01203412);
		chk("size ports", 32'h01203412, ports);
		wb(1'b1, 7'h3E, 32'h08700000);
		wb(1'b1, 7'h3E, 32'h00000009);
		wb(1'b1, 7'h3E, 32'h09000000);
		rdc("size refused", 7'h3E, 32'h01203412);
		wb(1'b1, 7'h3E, 32'h01203411);
		u_host_mac_model.move(3, 1'b0, 0);
		rdc("level", 7'h40, 32'h3);
		rdc("frames", 7'h3F, 32'h1);
		rdc("armed", 7'h4A, 32'h0);
		u_host_mac_model.move(3, 1'b1, 2);
		rdc("level", 7'h40, 32'h0);
		rdc("frames", 7'h3F, 32'h0);
		wb(1'b1, 7'h3E, 32'h01111111);
		rdc("size unarmed", 7'h3E, 32'h01203411);
		u_host_mac_model.move(1024, 1'b0, 0);
		chk("full", 32'h1, {31'h0, HTX_FULL});
		wb(1'b1, 7'h4C, 32'h1);
		chk("irq", 32'h0, {31'h0, IRQ});
		u_host_mac_model.move(4, 1'b0, 0);
		rdc("drops", 7'h41, 32'h1);
		rdc("level", 7'h40, 32'h400);
		rdc("frames", 7'h3F, 32'h1);
		chk("irq", 32'h1, {31'h0, IRQ});
		wb(1'b1, 7'h41, 32'hFFFFFFFF);
		rdc("drops", 7'h41, 32'h1);
		wb(1'b1, 7'h4B, 32'h3);
		chk("irq", 32'h0, {31'h0, IRQ});
		wb(1'b1, 7'h4A, 32'h1);
		rdc("level cleared", 7'h40, 32'h0);
		rdc("frames cleared", 7'h3F, 32'h0);
		chk("full cleared", 32'h0, {31'h0, HTX_FULL});
		do_reset;
		rdc("size reset", 7'h3E, 32'h02222222);
		rdc("drops reset", 7'h41, 32'h0);
		stop_test;
	end
endmodule
